//--- count_divider.sv
// Programmable divider: one pulse per divisor ticks
`timescale 1ns/1ps
module count_divider #(
   parameter int W = 14
) (
   input  wire logic         clk_sys,
   input  wire logic         reset,
   input  wire logic         run,
   input  wire logic         restart,
   input  wire logic         tick,
   input  wire logic [W-1:0] divisor,
   output logic              pulse_q
);
   logic [W-1:0] count_q;
   logic [W:0]   next_count;

   assign next_count = {1'b0, count_q} + {{W{1'b0}}, 1'b1};

   // Divisor zero behaves as one so the output never stalls
   always_ff @(posedge clk_sys) begin
      if (reset || !run || restart) begin
         count_q <= '0;
         pulse_q <= 1'b0;
      end else if (tick) begin
         if (next_count >= {1'b0, divisor}) begin
            count_q <= '0;
            pulse_q <= 1'b1;
         end else begin
            count_q <= next_count[W-1:0];
            pulse_q <= 1'b0;
         end
      end else begin
         pulse_q <= 1'b0;
      end
   end
endmodule : count_divider

//--- sample_clock_synth_control.sv
// Digital control of the integer-N sample clock synthesizer
//
// Operation
// - 14-bit reference and 13-bit feedback dividers
// - Output clock is reference times N over R
// - Nominal pump current is code plus one steps
// - Fast acquire flag boosts pump after channel change
// - Fast acquire threshold uses own 12-bit divisor
// - Synthesizer standby bit disables the synthesizer
// - Oscillator bias from bits 3:2 of register
// - Detector compares divided clocks, drives up/down
// - Divisor divides reference giving time unit T
// - Pulse over k T gives k+1 times, max eight
// - Boost only raises; code zero floors at two
`timescale 1ns/1ps
`include "synth_ctl_params.svh"
module sample_clock_synth_control
   import synth_ctl_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       reset,
   input  wire logic       spi_clk,
   input  wire logic       spi_sel_n,
   input  wire logic       spi_mosi,
   output logic            spi_miso_q,
   output logic            spi_miso_oe_q,
   input  wire logic       fref_in,
   input  wire logic       osc_in,
   output logic            pump_up_q,
   output logic            pump_down_q,
   output logic [3:0]      pump_level_q,
   output logic            synth_enable_q,
   output logic            osc_enable_q,
   output logic [1:0]      osc_bias_q,
   output logic [1:0]      test_select_q
);
   logic                   wr_stb;
   logic [`ADDR_W-1:0]     addr;
   logic [7:0]             wr_data;
   logic [7:0]             rd_data;

   logic [7:0]             standby_q;
   logic [1:0]             bias_q;
   logic [5:0]             ref_hi_q;
   logic [7:0]             ref_lo_q;
   logic [4:0]             fb_hi_q;
   logic [7:0]             fb_lo_q;
   logic [7:0]             pump_ctl_q;
   logic [3:0]             fa_hi_q;
   logic [7:0]             fa_lo_q;

   logic [`REF_DIV_W-1:0]  ref_div_value;
   logic [`FB_DIV_W-1:0]   fb_div_value;
   logic [`FA_DIV_W-1:0]   fa_div_value;
   logic                   synth_run;
   logic                   fast_acquire_enable;
   logic                   clock_pfd_polarity;
   logic [2:0]             pump_current_code;

   logic [1:0]             pin_meta_q;
   logic [1:0]             pin_sync_q;
   logic [1:0]             pin_prev_q;
   logic                   fref_edge;
   logic                   osc_edge;
   logic                   ref_pulse;
   logic                   fb_pulse;
   logic                   t_tick;

   pfd_state_type          pfd_q;
   pfd_state_type          pfd_d;
   logic                   pulse_start;
   logic                   pulse_end;
   logic [2:0]             width_q;
   logic [3:0]             level_d;

   serial_port port_i (
      .clk_sys       (clk_sys),
      .reset         (reset),
      .spi_clk       (spi_clk),
      .spi_sel_n     (spi_sel_n),
      .spi_mosi      (spi_mosi),
      .rd_data       (rd_data),
      .spi_miso_q    (spi_miso_q),
      .spi_miso_oe_q (spi_miso_oe_q),
      .wr_stb_q      (wr_stb),
      .addr_q        (addr),
      .wr_data_q     (wr_data)
   );

   // Register writes
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         standby_q  <= `RST_STANDBY;
         bias_q     <= `RST_OSC_BIAS;
         ref_hi_q   <= `RST_REF_DIV_HIGH;
         ref_lo_q   <= `RST_REF_DIV_LOW;
         fb_hi_q    <= `RST_FB_DIV_HIGH;
         fb_lo_q    <= `RST_FB_DIV_LOW;
         pump_ctl_q <= `RST_PUMP_CTL;
         fa_hi_q    <= `RST_FA_DIV_HIGH;
         fa_lo_q    <= `RST_FA_DIV_LOW;
      end else if (wr_stb) begin
         case (addr)
            `OFF_STANDBY:      standby_q  <= wr_data;
            `OFF_OSC_BIAS:     bias_q     <= wr_data[`BIAS_LSB+:2];
            `OFF_REF_DIV_HIGH: ref_hi_q   <= wr_data[5:0];
            `OFF_REF_DIV_LOW:  ref_lo_q   <= wr_data;
            `OFF_FB_DIV_HIGH:  fb_hi_q    <= wr_data[4:0];
            `OFF_FB_DIV_LOW:   fb_lo_q    <= wr_data;
            `OFF_PUMP_CTL:     pump_ctl_q <= {1'b0, wr_data[6:0]};
            `OFF_FA_DIV_HIGH:  fa_hi_q    <= wr_data[3:0];
            `OFF_FA_DIV_LOW:   fa_lo_q    <= wr_data;
            default: ;
         endcase
      end
   end

   // Unmapped addresses and reserved bits read as zero
   always_comb begin
      case (addr)
         `OFF_STANDBY:      rd_data = standby_q;
         `OFF_OSC_BIAS:     rd_data = {4'h0, bias_q, 2'h0};
         `OFF_REF_DIV_HIGH: rd_data = {2'h0, ref_hi_q};
         `OFF_REF_DIV_LOW:  rd_data = ref_lo_q;
         `OFF_FB_DIV_HIGH:  rd_data = {3'h0, fb_hi_q};
         `OFF_FB_DIV_LOW:   rd_data = fb_lo_q;
         `OFF_PUMP_CTL:     rd_data = pump_ctl_q;
         `OFF_FA_DIV_HIGH:  rd_data = {4'h0, fa_hi_q};
         `OFF_FA_DIV_LOW:   rd_data = fa_lo_q;
         default:           rd_data = 8'h00;
      endcase
   end

   assign ref_div_value = {ref_hi_q, ref_lo_q};
   assign fb_div_value  = {fb_hi_q, fb_lo_q};
   assign fa_div_value  = {2'h0, fa_hi_q, fa_lo_q};

   assign synth_run           = !standby_q[`BLOCK_STANDBY_CONTROL_SYNTH_BIT];
   assign fast_acquire_enable = pump_ctl_q[`PUMP_FA_BIT];
   assign clock_pfd_polarity  = pump_ctl_q[`PUMP_INV_BIT];
   assign pump_current_code   = pump_ctl_q[`PUMP_CODE_LSB+:3];

   // Static control outputs
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         synth_enable_q <= 1'b0;
         osc_enable_q   <= 1'b0;
         osc_bias_q     <= 2'h0;
         test_select_q  <= 2'h0;
      end else begin
         synth_enable_q <= synth_run;
         osc_enable_q   <= !standby_q[`BLOCK_STANDBY_CONTROL_OSC_BIT];
         osc_bias_q     <= bias_q;
         test_select_q  <= pump_ctl_q[`PUMP_TEST_LSB+:2];
      end
   end

   // Reference and oscillator pins are asynchronous: two flops, then edge detect
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         pin_meta_q <= 2'h0;
         pin_sync_q <= 2'h0;
         pin_prev_q <= 2'h0;
      end else begin
         pin_meta_q <= {osc_in, fref_in};
         pin_sync_q <= pin_meta_q;
         pin_prev_q <= pin_sync_q;
      end
   end

   assign fref_edge = pin_sync_q[0] && !pin_prev_q[0];
   assign osc_edge  = pin_sync_q[1] && !pin_prev_q[1];

   count_divider #(.W(`REF_DIV_W)) ref_div_i (
      .clk_sys (clk_sys),
      .reset   (reset),
      .run     (synth_run),
      .restart (1'b0),
      .tick    (fref_edge),
      .divisor (ref_div_value),
      .pulse_q (ref_pulse)
   );

   // Plain N count, no prefix stage: f_out = f_ref * N / R
   count_divider #(.W(`FB_DIV_W)) fb_div_i (
      .clk_sys (clk_sys),
      .reset   (reset),
      .run     (synth_run),
      .restart (1'b0),
      .tick    (osc_edge),
      .divisor (fb_div_value),
      .pulse_q (fb_pulse)
   );

   // Restarted at each detector pulse so width is measured from its start
   count_divider #(.W(`FA_DIV_W)) fa_div_i (
      .clk_sys (clk_sys),
      .reset   (reset),
      .run     (synth_run),
      .restart (pulse_start),
      .tick    (fref_edge),
      .divisor (fa_div_value),
      .pulse_q (t_tick)
   );

   // Phase/frequency detector; both edges together cancel
   always_comb begin
      case (pfd_q)
         PFD_IDLE: begin
            if (ref_pulse && !fb_pulse) begin
               pfd_d = PFD_UP;
            end else if (fb_pulse && !ref_pulse) begin
               pfd_d = PFD_DOWN;
            end else begin
               pfd_d = PFD_IDLE;
            end
         end
         PFD_UP:   pfd_d = fb_pulse ? PFD_IDLE : PFD_UP;
         PFD_DOWN: pfd_d = ref_pulse ? PFD_IDLE : PFD_DOWN;
         default:  pfd_d = PFD_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (reset || !synth_run) begin
         pfd_q       <= PFD_IDLE;
         pump_up_q   <= 1'b0;
         pump_down_q <= 1'b0;
      end else begin
         pfd_q       <= pfd_d;
         pump_up_q   <= (pfd_d == (clock_pfd_polarity ? PFD_DOWN : PFD_UP));
         pump_down_q <= (pfd_d == (clock_pfd_polarity ? PFD_UP : PFD_DOWN));
      end
   end

   assign pulse_start = (pfd_q == PFD_IDLE) && (pfd_d != PFD_IDLE);
   assign pulse_end   = (pfd_q != PFD_IDLE) && (pfd_d == PFD_IDLE);

   // Whole periods of T inside the current pulse, saturating at seven
   always_ff @(posedge clk_sys) begin
      if (reset || pulse_start) begin
         width_q <= 3'h0;
      end else if (t_tick && pfd_q != PFD_IDLE && width_q != `WIDTH_MAX) begin
         width_q <= width_q + 3'h1;
      end
   end

   // Level for the next pulse in units of the minimum current
   always_comb begin
      level_d = {1'b0, pump_current_code} + 4'h1;
      if (fast_acquire_enable) begin
         if (width_q > pump_current_code) begin
            level_d = {1'b0, width_q} + 4'h1;
         end
         if (level_d < 4'h2) begin
            level_d = 4'h2;
         end
      end
   end

   // Held between pulses; a code change shows at the next pulse end, or on the next cycle in standby
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         pump_level_q <= 4'h1;
      end else if (pulse_end || !synth_run) begin
         pump_level_q <= level_d;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   chk_ref_div_load: assert property (
      wr_stb && addr == `OFF_REF_DIV_LOW |=> ref_div_value[7:0] == $past(wr_data))
      else $error("reference divider low byte not taken");
   chk_bias_field: assert property (
      wr_stb && addr == `OFF_OSC_BIAS |=> ##1 osc_bias_q == $past(wr_data[3:2], 2))
      else $error("oscillator bias field wrong");
   chk_standby_quiet: assert property (
      !synth_run |=> !pump_up_q && !pump_down_q && !ref_pulse)
      else $error("pump active in standby");
   chk_pfd_exclusive: assert property (
      !(pump_up_q && pump_down_q))
      else $error("up and down together");
   chk_pfd_start: assert property (
      synth_run && pfd_q == PFD_IDLE && ref_pulse && !fb_pulse && !clock_pfd_polarity
      |=> pump_up_q)
      else $error("reference lead gave no up pulse");
   chk_nominal_level: assert property (
      pulse_end && !fast_acquire_enable
      |=> pump_level_q == {1'b0, $past(pump_current_code)} + 4'h1)
      else $error("nominal pump level wrong");
   chk_fa_floor: assert property (
      pulse_end && fast_acquire_enable |=> pump_level_q >= 4'h2
      && pump_level_q >= {1'b0, $past(pump_current_code)} + 4'h1)
      else $error("fast acquire lowered current");
   chk_fa_cap: assert property (
      pump_level_q <= `LEVEL_MAX && pump_level_q != 4'h0)
      else $error("pump level out of range");
   chk_osc_enable: assert property (
      ##1 osc_enable_q == !$past(standby_q[`BLOCK_STANDBY_CONTROL_OSC_BIT]))
      else $error("oscillator enable does not follow standby");
endmodule : sample_clock_synth_control

//--- serial_port.sv
// Serial register port: 16-bit frames, read flag, 7-bit address, 8-bit data
`timescale 1ns/1ps
`include "synth_ctl_params.svh"
module serial_port (
   input  wire logic                clk_sys,
   input  wire logic                reset,
   input  wire logic                spi_clk,
   input  wire logic                spi_sel_n,
   input  wire logic                spi_mosi,
   input  wire logic [7:0]          rd_data,
   output logic                     spi_miso_q,
   output logic                     spi_miso_oe_q,
   output logic                     wr_stb_q,
   output logic [`ADDR_W-1:0]       addr_q,
   output logic [7:0]               wr_data_q
);
   logic [2:0] meta_q;
   logic [2:0] sync_q;
   logic       clk_prev_q;
   logic [4:0] cnt_q;
   logic [6:0] shift_q;
   logic [7:0] rd_shift_q;
   logic       read_q;
   logic       rise;
   logic       fall;
   logic       sel;

   // Pins are asynchronous; spi_clk must be no faster than clk_sys/8
   // Reset to the idle pin levels so no false select or clock edge follows
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         meta_q     <= 3'h4;
         sync_q     <= 3'h4;
         clk_prev_q <= 1'b0;
      end else begin
         meta_q     <= {spi_sel_n, spi_mosi, spi_clk};
         sync_q     <= meta_q;
         clk_prev_q <= sync_q[0];
      end
   end

   assign sel  = !sync_q[2];
   assign rise = sel && sync_q[0] && !clk_prev_q;
   assign fall = sel && !sync_q[0] && clk_prev_q;

   always_ff @(posedge clk_sys) begin
      if (reset || !sel) begin
         cnt_q    <= 5'h00;
         shift_q  <= 7'h00;
         read_q   <= 1'b0;
         addr_q   <= '0;
         wr_stb_q <= 1'b0;
         wr_data_q <= 8'h00;
      end else begin
         wr_stb_q <= 1'b0;
         if (rise && cnt_q < 5'h10) begin
            shift_q <= {shift_q[5:0], sync_q[1]};
            cnt_q   <= cnt_q + 5'h01;
            if (cnt_q == 5'h07) begin
               read_q <= shift_q[6];
               addr_q <= {shift_q[5:0], sync_q[1]};
            end
            if (cnt_q == 5'h0f) begin
               wr_stb_q  <= !read_q;
               wr_data_q <= {shift_q, sync_q[1]};
            end
         end
      end
   end

   // Read data leaves on falling edges so the master samples it on rising ones
   always_ff @(posedge clk_sys) begin
      if (reset || !sel) begin
         spi_miso_q    <= 1'b0;
         spi_miso_oe_q <= 1'b0;
         rd_shift_q    <= 8'h00;
      end else if (fall && read_q && cnt_q >= 5'h08) begin
         spi_miso_oe_q <= 1'b1;
         if (cnt_q == 5'h08) begin
            spi_miso_q <= rd_data[7];
            rd_shift_q <= {rd_data[6:0], 1'b0};
         end else begin
            spi_miso_q <= rd_shift_q[7];
            rd_shift_q <= {rd_shift_q[6:0], 1'b0};
         end
      end
   end
endmodule : serial_port

//--- synth_ctl_params.svh
// Register map, field positions and reset values of the clock synthesizer control
`ifndef SYNTH_CTL_PARAMS_SVH
`define SYNTH_CTL_PARAMS_SVH

`define ADDR_W              7
`define OFF_STANDBY         7'h00
`define OFF_OSC_BIAS        7'h01
`define OFF_REF_DIV_HIGH    7'h10
`define OFF_REF_DIV_LOW     7'h11
`define OFF_FB_DIV_HIGH     7'h12
`define OFF_FB_DIV_LOW      7'h13
`define OFF_PUMP_CTL        7'h14
`define OFF_FA_DIV_HIGH     7'h15
`define OFF_FA_DIV_LOW      7'h16

`define RST_STANDBY         8'hff
`define RST_OSC_BIAS        2'h0
`define RST_REF_DIV_HIGH    6'h00
`define RST_REF_DIV_LOW     8'h38
`define RST_FB_DIV_HIGH     5'h00
`define RST_FB_DIV_LOW      8'h3c
`define RST_PUMP_CTL        8'h00
`define RST_FA_DIV_HIGH     4'h0
`define RST_FA_DIV_LOW      8'h04

`define BLOCK_STANDBY_CONTROL_SYNTH_BIT      1
`define BLOCK_STANDBY_CONTROL_OSC_BIT        0
`define BIAS_LSB            2
`define PUMP_FA_BIT         6
`define PUMP_INV_BIT        5
`define PUMP_CODE_LSB       2
`define PUMP_TEST_LSB       0

`define REF_DIV_W           14
`define FB_DIV_W            13
`define FA_DIV_W            14
`define LEVEL_MAX           4'h8
`define WIDTH_MAX           3'h7

`endif

//--- synth_ctl_pkg.sv
// Types shared by the clock synthesizer control
package synth_ctl_pkg;
   typedef enum logic [1:0] {
      PFD_IDLE = 2'b00,
      PFD_UP   = 2'b01,
      PFD_DOWN = 2'b10
   } pfd_state_type;
endpackage : synth_ctl_pkg

//--- synth_partner.sv
// Reference oscillator and external VCO stand-in with programmable periods
`timescale 1ns/1ps
module synth_partner (
   input  wire logic       clk_sys,
   input  wire logic       hold,
   input  wire logic [7:0] ref_half,
   input  wire logic [7:0] osc_half,
   input  wire logic [7:0] osc_delay,
   output logic            fref_in,
   output logic            osc_in
);
   int ref_cnt;
   int osc_cnt;
   // Both sources rest low while held, so every run starts from a known phase
   always_ff @(posedge clk_sys) begin
      if (hold) begin
         ref_cnt <= 0;
         fref_in <= 1'b0;
      end else if (ref_cnt == int'(ref_half) - 1) begin
         ref_cnt <= 0;
         fref_in <= ~fref_in;
      end else begin
         ref_cnt <= ref_cnt + 1;
      end
   end
   // The oscillator lags by osc_delay cycles, which sets the detector pulse width
   always_ff @(posedge clk_sys) begin
      if (hold) begin
         osc_cnt <= -int'(osc_delay);
         osc_in  <= 1'b0;
      end else if (osc_cnt == int'(osc_half) - 1) begin
         osc_cnt <= 0;
         osc_in  <= ~osc_in;
      end else begin
         osc_cnt <= osc_cnt + 1;
      end
   end
endmodule : synth_partner

//--- test_sample_clock_synth_control.sv
// Self-checking bench for the sample clock synthesizer control
`timescale 1ns/1ps
module test_sample_clock_synth_control;
   logic       clk_sys, reset, spi_clk, spi_sel_n, spi_mosi, hold;
   logic       spi_miso_q, spi_miso_oe_q, fref_in, osc_in, pump_up_q, pump_down_q;
   logic       synth_enable_q, osc_enable_q;
   logic [3:0] pump_level_q;
   logic [1:0] osc_bias_q, test_select_q;
   logic [7:0] ref_half, osc_half, osc_delay;
   int         errors = 0;
   int         n_tests = 0;
   int         cyc = 0;
   localparam logic [6:0] ADR [9] = '{7'h00, 7'h01, 7'h10, 7'h11, 7'h12, 7'h13, 7'h14,
                                      7'h15, 7'h16};
   localparam logic [7:0] RST [9] = '{8'hff, 8'h00, 8'h00, 8'h38, 8'h00, 8'h3c, 8'h00,
                                      8'h00, 8'h04};
   localparam logic [7:0] MSK [9] = '{8'hff, 8'h0c, 8'h3f, 8'hff, 8'h1f, 8'hff, 8'h7f,
                                      8'h0f, 8'hff};

   sample_clock_synth_control i_sample_clock_synth_control (
      .clk_sys        (clk_sys),
      .reset          (reset),
      .spi_clk        (spi_clk),
      .spi_sel_n      (spi_sel_n),
      .spi_mosi       (spi_mosi),
      .spi_miso_q     (spi_miso_q),
      .spi_miso_oe_q  (spi_miso_oe_q),
      .fref_in        (fref_in),
      .osc_in         (osc_in),
      .pump_up_q      (pump_up_q),
      .pump_down_q    (pump_down_q),
      .pump_level_q   (pump_level_q),
      .synth_enable_q (synth_enable_q),
      .osc_enable_q   (osc_enable_q),
      .osc_bias_q     (osc_bias_q),
      .test_select_q  (test_select_q)
   );
   synth_partner i_synth_partner (
      .clk_sys   (clk_sys),
      .hold      (hold),
      .ref_half  (ref_half),
      .osc_half  (osc_half),
      .osc_delay (osc_delay),
      .fref_in   (fref_in),
      .osc_in    (osc_in)
   );

   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) cyc <= cyc + 1;

   task automatic complete_run;
      $display("tests %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : complete_run

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // Mode 0 frame at an eighth of the system clock, the fastest the port takes
   task automatic spi(input logic [15:0] f, output logic [7:0] rd, output logic [15:0] oe);
      spi_sel_n <= 1'b0;
      for (int i = 15; i >= 0; i--) begin
         spi_mosi <= f[i];
         repeat (4) @(posedge clk_sys);
         spi_clk <= 1'b1;
         oe[i] = spi_miso_oe_q;
         if (i < 8) rd[i] = spi_miso_q;
         repeat (4) @(posedge clk_sys);
         spi_clk <= 1'b0;
      end
      repeat (4) @(posedge clk_sys);
      spi_sel_n <= 1'b1;
      repeat (8) @(posedge clk_sys);
   endtask : spi

   // The data line is only driven in the data phase of a read
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0]  x;
      logic [15:0] oe;
      spi({1'b0, a, d}, x, oe);
      check("miso_oe write", oe, 16'h0000);
   endtask : wr

   task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
      logic [7:0]  x;
      logic [15:0] oe;
      spi({1'b1, a, 8'h00}, x, oe);
      check($sformatf("register %h", a), {8'h00, x}, {8'h00, e});
      check("miso_oe read", oe, 16'h00ff);
   endtask : rdchk

   // Waits for one whole pump pulse; o counts cycles with the other pump line high
   task automatic pulse(input bit dn, output int w, output int t, output int o);
      int n;
      n = 0;
      o = 0;
      w = 0;
      while ((dn ? pump_down_q : pump_up_q) === 1'b1 && n < 9000) begin
         @(posedge clk_sys);
         n++;
      end
      while ((dn ? pump_down_q : pump_up_q) !== 1'b1 && n < 9000) begin
         @(posedge clk_sys);
         n++;
      end
      t = cyc;
      while ((dn ? pump_down_q : pump_up_q) === 1'b1 && n < 9000) begin
         if ((dn ? pump_up_q : pump_down_q) !== 1'b0) o++;
         @(posedge clk_sys);
         n++;
         w++;
      end
      if (n >= 9000) check("pulse wait", 16'h1, 16'h0);
      repeat (2) @(posedge clk_sys);
   endtask : pulse

   task automatic level(input bit dn, input logic [3:0] e);
      int w, t, o;
      pulse(dn, w, t, o);
      pulse(dn, w, t, o);
      check("pump_level", {12'h000, pump_level_q}, {12'h000, e});
   endtask : level

   // Standby clears the loop, then both sources restart together
   task automatic setup(input logic [13:0] r, input logic [12:0] n, input logic [7:0] p,
                        input logic [7:0] d);
      wr(7'h10, {2'b00, r[13:8]});
      wr(7'h11, r[7:0]);
      wr(7'h12, {3'b000, n[12:8]});
      wr(7'h13, n[7:0]);
      wr(7'h14, p);
      wr(7'h00, 8'hff);
      hold <= 1'b1;
      osc_delay <= d;
      repeat (2) @(posedge clk_sys);
      wr(7'h00, 8'h01);
      hold <= 1'b0;
   endtask : setup

   task automatic reset_values;
      check("synth_enable", synth_enable_q, 16'h0);
      check("osc_enable", osc_enable_q, 16'h0);
      check("pump_level", pump_level_q, 16'h1);
      check("osc_bias", osc_bias_q, 16'h0);
      for (int i = 0; i < 9; i++) rdchk(ADR[i], RST[i]);
      rdchk(7'h20, 8'h00);
   endtask : reset_values

   task automatic write_read;
      for (int i = 0; i < 9; i++) wr(ADR[i], 8'hff);
      for (int i = 0; i < 9; i++) rdchk(ADR[i], MSK[i]);
      check("test_select", test_select_q, 16'h3);
      wr(7'h20, 8'h5a);
      rdchk(7'h20, 8'h00);
      for (int b = 0; b < 4; b++) begin
         wr(7'h01, 8'(b << 2));
         check("osc_bias", osc_bias_q, 16'(b));
      end
   endtask : write_read

   task automatic standby;
      wr(7'h00, 8'h02);
      check("synth_enable", synth_enable_q, 16'h0);
      check("osc_enable", osc_enable_q, 16'h1);
      wr(7'h00, 8'h01);
      check("synth_enable", synth_enable_q, 16'h1);
      check("osc_enable", osc_enable_q, 16'h0);
   endtask : standby

   // R=3 on a 16-cycle reference and N=2 on a 24-cycle oscillator meet every 48
   task automatic lock;
      int w1, w2, t1, t2, o1, o2;
      setup(14'd3, 13'd2, 8'h1c, 8'd12);
      pulse(1'b0, w1, t1, o1);
      pulse(1'b0, w2, t2, o2);
      check("pulse period", 16'(t2 - t1), 16'd48);
      check("pulse width", 16'(w2), 16'(w1));
      check("opposite pump", 16'(o1 + o2), 16'h0);
      check("pump_level", pump_level_q, 16'h8);
      for (int c = 0; c < 8; c++) begin
         wr(7'h14, 8'(c << 2));
         level(1'b0, 4'(c + 1));
      end
   endtask : lock

   task automatic polarity;
      int w, t, o;
      wr(7'h14, 8'h28);
      pulse(1'b1, w, t, o);
      pulse(1'b1, w, t, o);
      check("opposite pump", 16'(o), 16'h0);
      check("pump_level", pump_level_q, 16'h3);
   endtask : polarity

   // A 36 to 44 cycle pulse holds two 16-cycle periods but no 64-cycle one
   task automatic fast_acq;
      wr(7'h15, 8'h00);
      wr(7'h16, 8'h01);
      setup(14'd3, 13'd2, 8'h40, 8'd40);
      level(1'b0, 4'h3);
      wr(7'h14, 8'h44);
      level(1'b0, 4'h3);
      wr(7'h14, 8'h50);
      level(1'b0, 4'h5);
      wr(7'h14, 8'h5c);
      level(1'b0, 4'h8);
      wr(7'h14, 8'h00);
      level(1'b0, 4'h1);
      wr(7'h16, 8'h04);
      wr(7'h14, 8'h40);
      level(1'b0, 4'h2);
      setup(14'd3, 13'd2, 8'h40, 8'd12);
      level(1'b0, 4'h2);
   endtask : fast_acq

   task automatic wide;
      int w, t1, t2, o;
      osc_half <= 8'd8;
      setup(14'h100, 13'h100, 8'h00, 8'd4);
      pulse(1'b0, w, t1, o);
      pulse(1'b0, w, t2, o);
      check("pulse period", 16'(t2 - t1), 16'd4096);
      wr(7'h00, 8'hff);
      repeat (64) @(posedge clk_sys);
      check("pump up", pump_up_q, 16'h0);
      check("pump down", pump_down_q, 16'h0);
   endtask : wide

   // Whole run needs some 22000 cycles
   initial begin
      repeat (60000) @(posedge clk_sys);
      errors++;
      complete_run();
   end

   initial begin
      reset = 1'b1;
      spi_clk = 1'b0;
      spi_sel_n = 1'b1;
      spi_mosi = 1'b0;
      hold = 1'b1;
      ref_half = 8'd8;
      osc_half = 8'd12;
      osc_delay = 8'd12;
      repeat (6) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      hold <= 1'b0;
      reset_values();
      write_read();
      standby();
      lock();
      polarity();
      fast_acq();
      wide();
      complete_run();
   end
endmodule : test_sample_clock_synth_control
